// ---- src/dma_slot_pkg.sv ----
// What this block does
// [R1] hold granted only at cycle end or idle
// [R2] hold: cpu not ready, detached, enable returned
// [R3] dma holds bus; cpu waits capped at six
// [R4] dropping hold request returns bus to cpu
// [R5] ch0 disk, ch1 floppy, ch2 refresh, ch3 user
// [R6] single transfer mode on every channel
// [R7] refresh request every 13 us to channel 2
// [R8] floppy request passes a delay stage
// [R9] address 15:8 latched from data on strobe
// [R10] page latch at 50H gives address 19:16
// [R11] zero-wait ready gets one wait, refresh none
// [R12] dma domain signals synchronised before use
// [R13] user channel moves bytes only
// [R14] channel 3 request is open collector
// [R15] gate bit 7 written at AEH, read at AFH
// [R16] request and grant qualified by gate bit
// [R17] request held until grant returns
// [R18] upper data lines pulled up on the board
// [R19] board signals end of transfer by interrupt
// [R20] software opens gate with 80H, ch3 only
// [R21] at most 64 KB per operation
// [R22] gate bit closed after reset
// Purpose: constants shared by both ends
// Assumes: one 50 MHz clock at both ends
// Notes:   10-bit i/o addresses
package dma_slot_pkg;
    localparam int          IO_AW             = 10;
    localparam logic [9:0]  PAGE_PORT         = 10'h050;
    localparam logic [9:0]  GATE_WRITE_PORT   = 10'h0AE;
    localparam logic [9:0]  GATE_READ_PORT    = 10'h0AF;
    localparam int          GATE_BIT          = 7;
    localparam logic [7:0]  GATE_OPEN_VALUE   = 8'h80;
    localparam int          PAGE_LSB          = 4;
    localparam int          CH_HARD_DISK      = 0;
    localparam int          CH_FLOPPY         = 1;
    localparam int          CH_REFRESH        = 2;
    localparam int          CH_USER           = 3;
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          REFRESH_PERIOD_NS = 13000;
    localparam int          REFRESH_CYCLES    = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          HOLD_MAX_WAITS    = 6;
    localparam int          FLOPPY_DELAY      = 4;
    localparam int          MAX_BYTES         = 65536;

    typedef enum logic [1:0] {
        BOARD_IDLE = 2'b00,
        BOARD_REQ  = 2'b01,
        BOARD_XFER = 2'b10,
        BOARD_END  = 2'b11
    } board_state_type;

    // exact port match, shared by both ends
    function automatic logic io_hit(input logic [9:0] a, input logic [9:0] port);
        return a == port;
    endfunction
endpackage

// ---- src/slot_link_if.sv ----
// Purpose: slot wiring between both ends
// Assumes: one clock; open collector request resolved here
// Notes:   request line low while any board pulls
`timescale 1ns/1ns
interface slot_link_if;
    logic [9:0] io_addr;        // cpu i/o address
    logic [7:0] io_wdata;       // cpu i/o write data
    logic       io_wr;          // i/o write strobe
    logic       io_rd;          // i/o read strobe
    logic [7:0] io_rdata;       // board read data
    logic       req_o;          // board request pin output level
    logic       req_oe;         // board request pin pulling
    logic       req_line_n;     // resolved wired-or request line
    logic       grant_n;        // channel 3 grant, active low
    logic       tc;             // terminal count from dma side
    logic [7:0] data_lo_o;      // board data d0-d7
    logic       data_lo_oe;     // board drives d0-d7
    logic       data_hi_oe;     // board drives d8-d15
    logic       data_hi_pullup; // board fits pull-ups on d8-d15
    logic       irq_n;          // end interrupt, active low

    // a pulling board forces the line to its output level
    assign req_line_n = req_oe ? req_o : 1'b1;

    modport system_end (
        output io_addr, io_wdata, io_wr, io_rd, grant_n, tc,
        input  io_rdata, req_line_n, data_lo_o, data_lo_oe, data_hi_oe, data_hi_pullup, irq_n
    );
    modport slot_end (
        input  io_addr, io_wdata, io_wr, io_rd, grant_n, tc,
        output io_rdata, req_o, req_oe, data_lo_o, data_lo_oe, data_hi_oe, data_hi_pullup, irq_n
    );
endinterface

// ---- src/sync_two_flop.sv ----
// Purpose: two flip-flop level synchroniser
// Assumes: levels stable two clocks or more
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ns
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  logic             clk,     // system clock
    input  logic             reset_n, // async reset, active low
    input  logic [WIDTH-1:0] d,       // foreign domain level
    output logic [WIDTH-1:0] q        // synchronised level
);
    logic [WIDTH-1:0] meta_ff;

    // reset value zero: all synchronised levels idle low here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ---- src/dma_hold_unit.sv ----
// Purpose: hold conversion, channel map, page latch
// Assumes: dma controller signals are asynchronous; cpu side on clk
// Notes:   hold lasts as long as the controller keeps its request
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module dma_hold_unit #(
    parameter int FLOPPY_DEPTH = dma_slot_pkg::FLOPPY_DELAY
) (
    input  logic        clk,                  // 50 MHz clock
    input  logic        reset_n,              // async reset, active low
    input  logic        cpu_cycle_active,     // cpu bus cycle in progress
    input  logic        dma_hold_request,     // hold request, dma domain
    output logic        hold_grant,           // hold acknowledge
    output logic        dma_transfer_enable,  // dma enable to controller
    output logic        cpu_not_ready,        // forces cpu wait
    output logic        cpu_bus_detach,       // cpu off system bus
    input  logic [3:0]  dma_ack,              // channel acks, dma domain
    input  logic        dma_end,              // terminal count, dma domain
    input  logic        hd_request,           // channel 0 slot request
    input  logic        floppy_request,       // floppy controller request
    output logic [3:0]  dma_request,          // requests to controller
    input  logic        upper_address_strobe, // address strobe, dma domain
    input  logic [7:0]  dma_addr_low,         // controller address 7:0
    input  logic [7:0]  dma_data,             // controller data 7:0
    output logic [19:0] dma_address,          // full dma address
    input  logic        mem_ready,            // memory ready
    input  logic        dma_cycle_start,      // first clock of a dma cycle
    output logic        dma_ready,            // ready to controller
    input  logic [9:0]  addr,                 // cpu i/o address
    input  logic [7:0]  wdata,                // cpu i/o write data
    input  logic        wr,                   // write strobe
    input  logic        rd,                   // read strobe
    output logic [7:0]  rdata,                // read data, cycle after rd
    slot_link_if.system_end link              // expansion slot
);
    initial begin
        if (FLOPPY_DEPTH < 1) $error("FLOPPY_DEPTH must be at least 1");
    end

    localparam int SYNC_W = 8;
    logic [SYNC_W-1:0] raw_async;
    logic [SYNC_W-1:0] sync_q;
    logic              hold_s;
    logic [3:0]        ack_s;
    logic              end_s;
    logic              strobe_s;
    logic              floppy_s;
    logic              hold_ff;
    logic [2:0]        wait_cnt_ff;
    logic [9:0]        refresh_cnt_ff;
    logic              refresh_req_ff;
    logic [FLOPPY_DEPTH-1:0] floppy_ff;
    logic [7:0]        upper_ff;
    logic [3:0]        page_ff;
    logic              first_ff;
    logic              rd_gate_ff;

    // every controller side control level crosses two flops first; address and data bytes do not
    assign raw_async = {floppy_request, upper_address_strobe, dma_end, dma_ack, dma_hold_request};
    sync_two_flop #(.WIDTH(SYNC_W)) u_sync (  // [R12]
        .clk     (clk),
        .reset_n (reset_n),
        .d       (raw_async),
        .q       (sync_q)
    );
    assign {floppy_s, strobe_s, end_s, ack_s, hold_s} = sync_q;

    // grant taken only outside a cpu cycle, dropped with the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_ff <= 1'b0;
        end else if (!hold_s) begin
            hold_ff <= 1'b0; // [R4]
        end else if (!cpu_cycle_active) begin
            hold_ff <= 1'b1; // [R1]
        end
    end

    assign hold_grant          = hold_ff;  // [R2]
    assign dma_transfer_enable = hold_ff;  // [R2]
    assign cpu_bus_detach      = hold_ff;  // [R2]

    // waits for a cpu cycle caught by a pending hold, six at most
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_cnt_ff <= 3'h0;
        end else if (!(hold_s && cpu_cycle_active) || hold_ff) begin
            wait_cnt_ff <= 3'h0;
        end else if (wait_cnt_ff != 3'(dma_slot_pkg::HOLD_MAX_WAITS)) begin
            wait_cnt_ff <= wait_cnt_ff + 3'h1; // [R3]
        end
    end

    assign cpu_not_ready = hold_ff ||
        (hold_s && cpu_cycle_active && wait_cnt_ff != 3'(dma_slot_pkg::HOLD_MAX_WAITS)); // [R3]

    // refresh tick; set wins over ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refresh_cnt_ff <= 10'h000;
            refresh_req_ff <= 1'b0;
        end else begin
            if (refresh_cnt_ff == 10'(dma_slot_pkg::REFRESH_CYCLES - 1)) begin
                refresh_cnt_ff <= 10'h000;
                refresh_req_ff <= 1'b1; // [R7]
            end else begin
                refresh_cnt_ff <= refresh_cnt_ff + 10'h001;
                if (ack_s[dma_slot_pkg::CH_REFRESH]) begin
                    refresh_req_ff <= 1'b0;
                end
            end
        end
    end

    // request must stay high through the line
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            floppy_ff <= '0;
        end else begin
            floppy_ff <= FLOPPY_DEPTH'({floppy_ff, floppy_s}) & {FLOPPY_DEPTH{floppy_s}};
        end
    end

    // channel map; the user line is active low on the slot
    always_comb begin
        dma_request                            = 4'h0;
        dma_request[dma_slot_pkg::CH_HARD_DISK] = hd_request;              // [R5]
        dma_request[dma_slot_pkg::CH_FLOPPY]   = floppy_ff[FLOPPY_DEPTH-1]; // [R8]
        dma_request[dma_slot_pkg::CH_REFRESH]  = refresh_req_ff;          // [R7]
        dma_request[dma_slot_pkg::CH_USER]     = ~link.req_line_n;        // [R5]
    end

    // upper address byte from data on strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upper_ff <= 8'h00;
        end else if (strobe_s) begin
            upper_ff <= dma_data; // [R9]
        end
    end

    // write-only page latch; only its high nibble is kept
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            page_ff <= 4'h0;
        end else if (wr && dma_slot_pkg::io_hit(addr, dma_slot_pkg::PAGE_PORT)) begin
            page_ff <= wdata[dma_slot_pkg::PAGE_LSB +: 4]; // [R10]
        end
    end

    assign dma_address = {page_ff, upper_ff, dma_addr_low}; // [R9] [R10]

    // a ready seen in the first clock is held back two clocks
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_ff <= 1'b0;
        end else begin
            first_ff <= dma_cycle_start;
        end
    end

    assign dma_ready = ack_s[dma_slot_pkg::CH_REFRESH] ? 1'b1 :
                       (mem_ready && !dma_cycle_start && !first_ff); // [R11]

    // only the gate readback answers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_gate_ff <= 1'b0;
        end else begin
            rd_gate_ff <= rd && dma_slot_pkg::io_hit(addr, dma_slot_pkg::GATE_READ_PORT);
        end
    end

    assign rdata         = rd_gate_ff ? link.io_rdata : 8'h00;
    assign link.io_addr  = addr;
    assign link.io_wdata = wdata;
    assign link.io_wr    = wr;
    assign link.io_rd    = rd;
    assign link.grant_n  = ~ack_s[dma_slot_pkg::CH_USER];
    assign link.tc       = end_s;
endmodule

// ---- src/slot_dma_board.sv ----
// Purpose: slot board moving bytes over channel 3
// Assumes: same clock as the system unit; one byte per request
// Notes:   a sample offered while the board is busy is refused
`timescale 1ns/1ns
module slot_dma_board #(
    parameter int MAX_XFER = dma_slot_pkg::MAX_BYTES
) (
    input  logic        clk,          // 50 MHz clock
    input  logic        reset_n,      // async reset, active low
    input  logic        user_valid,   // sample byte offered
    input  logic [7:0]  user_data,    // sample byte
    output logic        user_ready,   // board takes the sample
    input  logic        irq_clear,    // clears the end interrupt
    output logic        dma_irq,      // end of operation flag
    output logic        gate_open,    // user dma gate state
    output logic [16:0] byte_count,   // bytes moved in this operation
    slot_link_if.slot_end link        // expansion slot
);
    initial begin
        if (MAX_XFER < 1 || MAX_XFER > dma_slot_pkg::MAX_BYTES) begin
            $error("MAX_XFER must lie in 1..65536");
        end
    end

    localparam logic [16:0] LIMIT = 17'(MAX_XFER);

    dma_slot_pkg::board_state_type state_ff;
    dma_slot_pkg::board_state_type nxt_state;
    logic        gate_ff;
    logic [7:0]  data_ff;
    logic [7:0]  rdata_ff;
    logic [16:0] count_ff;
    logic        irq_ff;
    logic        granted;
    logic        gate_write;
    logic        gate_read;
    logic        last_byte;

    // i/o decode of the gate port pair
    assign gate_write = link.io_wr && dma_slot_pkg::io_hit(link.io_addr, dma_slot_pkg::GATE_WRITE_PORT);
    assign gate_read  = link.io_rd && dma_slot_pkg::io_hit(link.io_addr, dma_slot_pkg::GATE_READ_PORT);

    // grant only counts while the gate is open
    assign granted   = !link.grant_n && gate_ff; // [R16]
    assign last_byte = (count_ff + 17'h00001 == LIMIT) || link.tc;

    // gate bit; closed from reset until software opens it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_ff <= 1'b0; // [R22]
        end else if (gate_write) begin
            gate_ff <= link.io_wdata[dma_slot_pkg::GATE_BIT]; // [R15] [R20]
        end
    end

    // readback of the gate; zero outside the answer cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= 8'(gate_read && gate_ff) << dma_slot_pkg::GATE_BIT; // [R15]
        end
    end

    // next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dma_slot_pkg::BOARD_IDLE: begin
                if (user_valid && user_ready) begin
                    nxt_state = dma_slot_pkg::BOARD_REQ;
                end
            end
            dma_slot_pkg::BOARD_REQ: begin
                // request stays until its grant comes back or the gate closes
                if (!gate_ff) begin
                    nxt_state = dma_slot_pkg::BOARD_IDLE; // [R16]
                end else if (granted) begin
                    nxt_state = dma_slot_pkg::BOARD_XFER; // [R17]
                end
            end
            dma_slot_pkg::BOARD_XFER: begin
                // one byte per grant keeps the bus shared
                if (!granted) begin
                    nxt_state = last_byte ? dma_slot_pkg::BOARD_END
                                          : dma_slot_pkg::BOARD_IDLE; // [R6]
                end
            end
            dma_slot_pkg::BOARD_END: begin
                nxt_state = dma_slot_pkg::BOARD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= dma_slot_pkg::BOARD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // sample byte held for the whole request and grant
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ff <= 8'h00;
        end else if (user_valid && user_ready) begin
            data_ff <= user_data; // [R13]
        end
    end

    // writing 80H to the gate port starts a new count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= 17'h00000;
        end else if (gate_write && link.io_wdata == dma_slot_pkg::GATE_OPEN_VALUE) begin
            count_ff <= 17'h00000; // [R20]
        end else if (state_ff == dma_slot_pkg::BOARD_XFER && !granted) begin
            count_ff <= count_ff + 17'h00001; // [R21]
        end
    end

    // end interrupt; set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else if (state_ff == dma_slot_pkg::BOARD_END) begin
            irq_ff <= 1'b1; // [R19]
        end else if (irq_clear) begin
            irq_ff <= 1'b0;
        end
    end

    // no sample past the limit or with the gate shut
    assign user_ready = (state_ff == dma_slot_pkg::BOARD_IDLE) && gate_ff && (count_ff < LIMIT); // [R21]

    // pin only pulls low; the line is shared
    assign link.req_o  = 1'b0;                                                 // [R14]
    assign link.req_oe = (state_ff == dma_slot_pkg::BOARD_REQ) && gate_ff;     // [R16] [R17]

    // low lane only; high lane rests on pull-ups
    assign link.data_lo_o      = data_ff;
    assign link.data_lo_oe     = (state_ff == dma_slot_pkg::BOARD_XFER) && granted; // [R13]
    assign link.data_hi_oe     = 1'b0;  // [R13]
    assign link.data_hi_pullup = 1'b1;  // [R18]
    assign link.io_rdata       = rdata_ff;
    assign link.irq_n          = ~irq_ff; // [R19]

    assign dma_irq    = irq_ff;
    assign gate_open  = gate_ff;
    assign byte_count = count_ff;
endmodule

// ---- verif/dma_slot_assertions.sv ----
// Purpose: checks on the slot wires
// Assumes: one clock; gate rebuilt from i/o writes
// Notes:   slot side only
`timescale 1ns/1ns
module dma_slot_assertions (
    input logic       clk,            // clock
    input logic       reset_n,        // reset
    input logic [9:0] io_addr,        // i/o address
    input logic [7:0] io_wdata,       // write data
    input logic       io_wr,          // write strobe
    input logic       io_rd,          // read strobe
    input logic [7:0] io_rdata,       // read data
    input logic       req_o,          // pin level
    input logic       req_oe,         // pin pulling
    input logic       grant_n,        // grant, low
    input logic       tc,             // terminal count
    input logic       data_lo_oe,     // low lane drive
    input logic       data_hi_oe,     // high lane drive
    input logic       data_hi_pullup, // pull-ups
    input logic       irq_n           // interrupt, low
);
    logic gate_ff; // expected gate state

    // gate follows bit 7 of writes to the gate port; reset closes it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            gate_ff <= 1'b0;
        else if (io_wr && io_addr == dma_slot_pkg::GATE_WRITE_PORT)
            gate_ff <= io_wdata[7];
    end

    default clocking dcb @(posedge clk); endclocking
    default disable iff (!reset_n);

    byte_lane_a: assert property (!data_hi_oe) else $error("upper data lane driven");
    pull_up_a: assert property (data_hi_pullup) else $error("upper lane pull-ups missing");
    open_coll_a: assert property (req_oe |-> !req_o) else $error("request pin driven high");
    req_gated_a: assert property (req_oe |-> gate_ff) else $error("request while gate closed");
    xfer_gated_a: assert property (data_lo_oe |-> gate_ff && !grant_n) else $error("data without grant");
    req_hold_a: assert property (req_oe && grant_n && !io_wr |=> req_oe) else $error("request dropped early");
    grant_order_a: assert property ($rose(data_lo_oe) |-> $past(req_oe)) else $error("transfer without request");
    gate_read_a: assert property (
        io_rd && io_addr == dma_slot_pkg::GATE_READ_PORT |=> io_rdata == {$past(gate_ff), 7'h00})
        else $error("gate readback wrong");
    reset_shut_a: assert property ($rose(reset_n) |-> !req_oe ##1 !req_oe) else $error("request after reset");
    end_irq_a: assert property ($fell(data_lo_oe) && tc |-> ##[1:4] !irq_n) else $error("no end interrupt");
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for both ends
// Assumes: inputs change on clk edges
// Notes:   small depths keep the run short
`timescale 1ns/1ns
module tb;
    localparam int FD = 2; // floppy delay stage depth
    localparam int MX = 3; // bytes per operation
    logic        clk, reset_n, cpu_cycle_active, dma_hold_request, dma_end, hd_request, floppy_request;
    logic        upper_address_strobe, mem_ready, dma_cycle_start, wr, rd, user_valid, irq_clear;
    logic        hold_grant, dma_transfer_enable, cpu_not_ready, cpu_bus_detach, dma_ready;
    logic        user_ready, dma_irq, gate_open;
    logic [3:0]  dma_ack, dma_request;
    logic [7:0]  dma_addr_low, dma_data, wdata, rdata, user_data, d;
    logic [9:0]  addr;
    logic [16:0] byte_count;
    logic [19:0] dma_address;
    logic [31:0] seed;
    int          n_fail, check_count, n, nr, g;

    slot_link_if lnk();
    dma_hold_unit #(.FLOPPY_DEPTH(FD)) u_dma_hold_unit (
        .clk, .reset_n, .cpu_cycle_active, .dma_hold_request, .hold_grant, .dma_transfer_enable,
        .cpu_not_ready, .cpu_bus_detach, .dma_ack, .dma_end, .hd_request, .floppy_request, .dma_request,
        .upper_address_strobe, .dma_addr_low, .dma_data, .dma_address, .mem_ready, .dma_cycle_start,
        .dma_ready, .addr, .wdata, .wr, .rd, .rdata, .link(lnk)
    );
    slot_dma_board #(.MAX_XFER(MX)) u_slot_dma_board (
        .clk, .reset_n, .user_valid, .user_data, .user_ready, .irq_clear, .dma_irq, .gate_open,
        .byte_count, .link(lnk)
    );
    dma_slot_assertions u_dma_slot_assertions (
        .clk, .reset_n, .io_addr(lnk.io_addr), .io_wdata(lnk.io_wdata), .io_wr(lnk.io_wr),
        .io_rd(lnk.io_rd), .io_rdata(lnk.io_rdata), .req_o(lnk.req_o), .req_oe(lnk.req_oe),
        .grant_n(lnk.grant_n), .tc(lnk.tc), .data_lo_oe(lnk.data_lo_oe), .data_hi_oe(lnk.data_hi_oe),
        .data_hi_pullup(lnk.data_hi_pullup), .irq_n(lnk.irq_n)
    );

    // free-running clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // xorshift keeps stimulus repeatable from a fixed start
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic sig(input int w);
        case (w)
            0: return hold_grant;
            1: return dma_request[1];
            2: return dma_request[2];
            3: return dma_request[3];
            4: return lnk.data_lo_oe;
            5: return dma_irq;
            default: return user_ready;
        endcase
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // bounded wait; running out of time ends the run as a failure
    task automatic wait_sig(input int w, input logic lvl, input int lim);
        n = 0;
        while (sig(w) !== lvl) begin
            tick();
            n++;
            if (n == lim) begin
                n_fail++;
                final_report();
            end
        end
    endtask
    task automatic io_w(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic io_r(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // one byte over channel 3: offer, request, grant, release
    task automatic xfer(input logic end_flag, input logic [16:0] cnt, input logic irq_exp);
        d = rnd();
        @(posedge clk);
        user_valid <= 1'b1;
        user_data <= d;
        wait_sig(6, 1'b1, 10);
        @(posedge clk);
        user_valid <= 1'b0;
        wait_sig(3, 1'b1, 5);
        repeat (4) tick();
        chk(dma_request[3], 1'b1);
        @(posedge clk);
        dma_ack[3] <= 1'b1;
        dma_end <= end_flag;
        wait_sig(4, 1'b1, 6);
        chk(lnk.data_lo_o, d);
        @(posedge clk);
        dma_ack[3] <= 1'b0;
        repeat (8) tick();
        dma_end <= 1'b0;
        chk(byte_count, cnt);
        chk(dma_irq, irq_exp);
    endtask

    // main sequence
    initial begin
        seed = 32'h00000055;
        n_fail = 0;
        check_count = 0;
        reset_n = 1'b0;
        mem_ready = 1'b1;
        {cpu_cycle_active, dma_hold_request, dma_end, hd_request, floppy_request} = '0;
        {upper_address_strobe, dma_cycle_start, wr, rd, user_valid, irq_clear} = '0;
        {dma_ack, dma_addr_low, dma_data, addr, wdata, user_data} = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        wait_sig(2, 1'b1, 700);
        chk_n(n, 645, 652);
        mem_ready <= 1'b0;
        dma_ack[2] <= 1'b1;
        repeat (3) tick();
        chk({dma_ready, dma_request[2]}, 2'h2);
        dma_ack[2] <= 1'b0;
        mem_ready <= 1'b1;
        repeat (3) tick();
        dma_cycle_start <= 1'b1;
        #2;
        chk(dma_ready, 1'b0);
        tick();
        dma_cycle_start <= 1'b0;
        #2;
        chk(dma_ready, 1'b0);
        tick();
        chk(dma_ready, 1'b1);
        io_r(10'h0AF, 8'h00);
        io_r(10'h050, 8'h00);
        io_r(10'h1C3, 8'h00);
        d = rnd();
        io_w(10'h050, d);
        dma_addr_low <= rnd();
        dma_data <= rnd();
        upper_address_strobe <= 1'b1;
        repeat (3) tick();
        chk({dma_address[19:16], dma_address[7:0]}, {d[7:4], dma_addr_low});
        d = dma_data;
        upper_address_strobe <= 1'b0;
        repeat (4) tick();
        dma_data <= ~d;
        repeat (2) tick();
        chk(dma_address[15:8], d);
        hd_request <= 1'b1;
        @(posedge clk);
        floppy_request <= 1'b1;
        wait_sig(1, 1'b1, 20);
        chk_n(n, FD + 2, FD + 3);
        chk(dma_request[0], 1'b1);
        {hd_request, floppy_request} <= 2'h0;
        @(posedge clk);
        dma_hold_request <= 1'b1;
        wait_sig(0, 1'b1, 10);
        chk_n(n, 2, 3);
        chk({dma_transfer_enable, cpu_bus_detach, cpu_not_ready}, 3'h7);
        dma_hold_request <= 1'b0;
        wait_sig(0, 1'b0, 10);
        chk({cpu_bus_detach, cpu_not_ready}, 2'h0);
        cpu_cycle_active <= 1'b1;
        dma_hold_request <= 1'b1;
        nr = 0;
        g = 0;
        repeat (12) begin
            tick();
            nr += int'(cpu_not_ready === 1'b1);
            g += int'(hold_grant === 1'b1);
        end
        chk_n(nr, 1, 6);
        chk_n(g, 0, 0);
        cpu_cycle_active <= 1'b0;
        wait_sig(0, 1'b1, 4);
        chk(dma_transfer_enable, 1'b1);
        dma_hold_request <= 1'b0;
        wait_sig(0, 1'b0, 10);
        user_valid <= 1'b1;
        repeat (4) tick();
        chk({user_ready, dma_request[3]}, 2'h0);
        user_valid <= 1'b0;
        io_w(10'h0AE, 8'h80);
        io_r(10'h0AF, 8'h80);
        chk(gate_open, 1'b1);
        for (int k = 1; k <= MX; k++)
            xfer(1'b0, 17'(k), k == MX);
        chk(user_ready, 1'b0);
        @(posedge clk);
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        io_w(10'h0AE, 8'h80);
        chk({dma_irq, byte_count}, 18'h0);
        xfer(1'b1, 17'h00001, 1'b1);
        io_w(10'h0AE, 8'h00);
        io_r(10'h0AF, 8'h00);
        final_report();
    end
endmodule
